/* core/uart_irq_consts.vh */
`ifndef UART_IRQ_CONSTS_VH
`define UART_IRQ_CONSTS_VH

// Register offsets on the plain register port
`define REG_RX_DATA 3'h0
`define REG_IRQ_ENABLE 3'h1
`define REG_IDENT 3'h2
`define REG_FIFO_CTRL 3'h2
`define REG_LINE_STATUS 3'h5
`define REG_HS_STATUS 3'h6
`define REG_EVT_STATUS 3'h3
`define REG_EVT_MASK 3'h4
`define REG_TX_HOLD 3'h0

// Enable register fields
`define EN_RX_READY 0
`define EN_TX_EMPTY 1
`define EN_LINE 2
`define EN_HS 3
`define IRQ_ENABLE_RESET 4'h0

// Identification codes
`define ID_NONE 4'h1
`define ID_LINE 4'h6
`define ID_RX_READY 4'h4
`define ID_TIMEOUT 4'hC
`define ID_TX_EMPTY 4'h2
`define ID_HS 4'h0

// FIFO control fields
`define FC_ENABLE 0
`define FC_LEVEL_HI 7
`define FC_LEVEL_LO 6
`define FIFO_CTRL_RESET 8'h00

// Trigger levels in bytes
`define LEVEL_0 5'h01
`define LEVEL_1 5'h04
`define LEVEL_2 5'h08
`define LEVEL_3 5'h0E

// Timeout: character times and bit times per character
`define TIMEOUT_CHARS 4
`define BITS_PER_CHAR 10

`endif

/* core/uart_irq_prio.v */
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.vh"

// Picks the highest priority enabled source and encodes it
module uart_irq_prio (
   input wire line_in,
   input wire rx_ready_in,
   input wire timeout_in,
   input wire tx_empty_in,
   input wire hs_in,
   input wire fifo_en_in,
   output reg [3:0] code_out,
   output wire any_out
);
   // Any enabled source pending
   assign any_out = line_in | rx_ready_in | timeout_in | tx_empty_in | hs_in;

   // Fixed priority encoder
   always @* begin
      if (line_in) begin
         code_out = `ID_LINE;
      end else if (rx_ready_in) begin
         code_out = `ID_RX_READY;
      end else if (timeout_in) begin
         code_out = fifo_en_in ? `ID_TIMEOUT : `ID_RX_READY;
      end else if (tx_empty_in) begin
         code_out = `ID_TX_EMPTY;
      end else if (hs_in) begin
         code_out = `ID_HS;
      end else begin
         code_out = `ID_NONE;
      end
   end
endmodule // uart_irq_prio

`default_nettype wire

/* core/uart_rx_timeout.v */
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.vh"

// Counts bit times since the last receive FIFO access
module uart_rx_timeout (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire bit_tick_in,
   input wire has_data_in,
   input wire access_in,
   output reg expired_out
);
   localparam [6:0] LIMIT = `TIMEOUT_CHARS * `BITS_PER_CHAR;
   reg [6:0] bit_count;

   // Restart on access or empty, saturate at the limit
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit_count <= 7'h00;
         expired_out <= 1'b0;
      end else if (access_in || !has_data_in) begin
         bit_count <= 7'h00;
         expired_out <= 1'b0;
      end else if (bit_tick_in && bit_count != LIMIT) begin
         bit_count <= bit_count + 7'h01;
         expired_out <= (bit_count + 7'h01) == LIMIT;
      end
   end
endmodule // uart_rx_timeout

`default_nettype wire

/* core/uart_interrupt_identify_enable.v */
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_consts.vh"

module uart_interrupt_identify_enable (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire [2:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   input wire [7:0] rx_byte_in,
   input wire [4:0] rx_count_in,
   input wire bit_tick_in,
   input wire overrun_flag_in,
   input wire parity_error_flag_in,
   input wire framing_error_flag_in,
   input wire break_detect_flag_in,
   input wire tx_empty_in,
   input wire clear_to_send_change_in,
   input wire data_set_ready_change_in,
   input wire ring_trailing_edge_in,
   input wire carrier_detect_change_in,
   input wire [3:0] modem_lines_in,
   output wire rx_read_out,
   output wire tx_write_out,
   output reg [7:0] tx_data_out,
   output wire irq_out,
   output wire evt_irq_out
);

   ////////////////////////////////////////////////////////////////
   // Functions

   // Trigger level from the two level bits
   function [4:0] trigger_level;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: trigger_level = `LEVEL_0;
            2'h1: trigger_level = `LEVEL_1;
            2'h2: trigger_level = `LEVEL_2;
            default: trigger_level = `LEVEL_3;
         endcase
      end
   endfunction

   // Register access decode
   function hit;
      input strobe;
      input [2:0] addr;
      input [2:0] want;
      begin
         hit = strobe && (addr == want);
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Declarations

   reg [3:0] serial_interrupt_enable;
   reg [7:0] fifo_control_reg;
   reg [3:0] line_bits;
   reg [3:0] hs_bits;
   reg tx_pending;
   reg tx_empty_prev;
   reg [1:0] evt_status;
   reg [1:0] evt_mask;
   wire [3:0] ident_code;
   wire any_pending;
   wire timeout_hit;
   wire fifo_en;
   wire rx_has_data;
   wire rx_level_hit;
   wire src_line;
   wire src_rx;
   wire src_to;
   wire src_tx;
   wire src_hs;
   wire rd_rx;
   wire rd_ident;
   wire rd_line;
   wire rd_hs;
   wire wr_tx;
   wire [3:0] next_line_bits;
   wire [3:0] next_hs_bits;
   wire [7:0] ident_reg;
   wire irq_rise;
   reg irq_prev;

   assign fifo_en = fifo_control_reg[`FC_ENABLE];
   assign rd_rx = hit(rd_in, addr_in, `REG_RX_DATA);
   assign rd_ident = hit(rd_in, addr_in, `REG_IDENT);
   assign rd_line = hit(rd_in, addr_in, `REG_LINE_STATUS);
   assign rd_hs = hit(rd_in, addr_in, `REG_HS_STATUS);
   assign wr_tx = hit(wr_in, addr_in, `REG_TX_HOLD);
   assign rx_read_out = rd_rx;
   assign tx_write_out = wr_tx;

   ////////////////////////////////////////////////////////////////
   // Sticky source flags

   // New events join the held bits
   assign next_line_bits = line_bits | {break_detect_flag_in, framing_error_flag_in,
      parity_error_flag_in, overrun_flag_in};
   assign next_hs_bits = hs_bits | {carrier_detect_change_in, ring_trailing_edge_in,
      data_set_ready_change_in, clear_to_send_change_in};

   // Read clears, but an event in the same cycle survives
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         line_bits <= 4'h0;
         hs_bits <= 4'h0;
      end else begin
         if (rd_line) begin
            line_bits <= {break_detect_flag_in, framing_error_flag_in,
               parity_error_flag_in, overrun_flag_in};
         end else begin
            line_bits <= next_line_bits;
         end
         if (rd_hs) begin
            hs_bits <= {carrier_detect_change_in, ring_trailing_edge_in,
               data_set_ready_change_in, clear_to_send_change_in};
         end else begin
            hs_bits <= next_hs_bits;
         end
      end
   end

   // Transmit empty: set on rising empty, cleared by write or by an ident read that shows transmit empty
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_pending <= 1'b0;
         tx_empty_prev <= 1'b0;
      end else begin
         tx_empty_prev <= tx_empty_in;
         if (tx_empty_in && !tx_empty_prev) begin
            tx_pending <= 1'b1;
         end else if (wr_tx) begin
            tx_pending <= 1'b0;
         end else if (rd_ident && ident_code == `ID_TX_EMPTY) begin
            tx_pending <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Receive conditions

   assign rx_has_data = rx_count_in != 5'h00;
   // Level compare in FIFO mode, any byte otherwise
   assign rx_level_hit = fifo_en ?
      (rx_count_in >= trigger_level(fifo_control_reg[`FC_LEVEL_HI:`FC_LEVEL_LO])) :
      rx_has_data;

   uart_rx_timeout u_timeout (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .bit_tick_in(bit_tick_in),
      .has_data_in(rx_has_data & fifo_en),
      .access_in(rd_rx),
      .expired_out(timeout_hit)
   );

   ////////////////////////////////////////////////////////////////
   // Enable gating and priority

   assign src_line = (|line_bits) & serial_interrupt_enable[`EN_LINE];
   assign src_rx = rx_level_hit & serial_interrupt_enable[`EN_RX_READY];
   assign src_to = timeout_hit & serial_interrupt_enable[`EN_RX_READY];
   assign src_tx = tx_pending & serial_interrupt_enable[`EN_TX_EMPTY];
   assign src_hs = (|hs_bits) & serial_interrupt_enable[`EN_HS];

   uart_irq_prio u_prio (
      .line_in(src_line),
      .rx_ready_in(src_rx),
      .timeout_in(src_to),
      .tx_empty_in(src_tx),
      .hs_in(src_hs),
      .fifo_en_in(fifo_en),
      .code_out(ident_code),
      .any_out(any_pending)
   );

   assign irq_out = any_pending;
   assign ident_reg = {fifo_en, fifo_en, 2'b00, ident_code};

   ////////////////////////////////////////////////////////////////
   // Event status for the summary interrupt

   // True rising edge of the request, so a write-one clear sticks while it stays high
   assign irq_rise = any_pending & ~irq_prev;

   // Bit 0 latches a new request, bit 1 a line error; write one clears
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evt_status <= 2'b00;
         irq_prev <= 1'b0;
      end else begin
         irq_prev <= any_pending;
         evt_status <= (evt_status & ~(hit(wr_in, addr_in, `REG_EVT_STATUS) ?
            wdata_in[1:0] : 2'b00)) | {|next_line_bits & ~(|line_bits), irq_rise};
      end
   end
   assign evt_irq_out = |(evt_status & evt_mask);

   ////////////////////////////////////////////////////////////////
   // Register writes

   // Software-written controls
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial_interrupt_enable <= `IRQ_ENABLE_RESET;
         fifo_control_reg <= `FIFO_CTRL_RESET;
         evt_mask <= 2'b00;
         tx_data_out <= 8'h00;
      end else if (wr_in) begin
         case (addr_in)
            `REG_IRQ_ENABLE: serial_interrupt_enable <= wdata_in[3:0];
            `REG_FIFO_CTRL: fifo_control_reg <= {wdata_in[7:6], 2'b00, wdata_in[3], 2'b00,
               wdata_in[0]};
            `REG_EVT_MASK: evt_mask <= wdata_in[1:0];
            `REG_TX_HOLD: tx_data_out <= wdata_in;
            default: tx_data_out <= tx_data_out;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register reads

   // Read data stands one cycle after the strobe
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `REG_RX_DATA: rdata_out <= rx_byte_in;
            `REG_IRQ_ENABLE: rdata_out <= {4'h0, serial_interrupt_enable};
            `REG_IDENT: rdata_out <= ident_reg;
            `REG_EVT_STATUS: rdata_out <= {6'h00, evt_status};
            `REG_EVT_MASK: rdata_out <= {6'h00, evt_mask};
            `REG_LINE_STATUS: rdata_out <= {4'h0, line_bits};
            `REG_HS_STATUS: rdata_out <= {modem_lines_in, hs_bits};
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

endmodule // uart_interrupt_identify_enable

`default_nettype wire

/* sim/uart_irq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_irq_chk (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic irq_out,
   input wire logic evt_irq_out
);
   logic [3:0] en;
   logic fe;
   wire id_rd = rd_in && addr_in == 3'h2;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////
   // Shadow of enable bits and FIFO mode from bus writes
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en <= 4'h0;
         fe <= 1'b0;
      end else if (wr_in && addr_in == 3'h1) begin
         en <= wdata_in[3:0];
      end else if (wr_in && addr_in == 3'h2) begin
         fe <= wdata_in[0];
      end
   end
   ////////////////////////////////////////////////////////////
   // Properties on enable and ident reads and request output
   property p_all_off;
      en == 4'h0 |-> !irq_out;
   endproperty
   a_all_off: assert property (p_all_off) else $error("request with enables off");
   property p_en_read;
      $past(rd_in && addr_in == 3'h1) |-> rdata_out[7:4] == 4'h0;
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable upper bits set");
   property p_idle_bit;
      $past(id_rd) |-> rdata_out[0] == !$past(irq_out);
   endproperty
   a_idle_bit: assert property (p_idle_bit) else $error("ident bit 0 wrong");
   property p_b3;
      $past(id_rd && !fe) |-> !rdata_out[3];
   endproperty
   a_b3: assert property (p_b3) else $error("ident bit 3 outside FIFO mode");
   property p_b76;
      $past(id_rd) |-> rdata_out[7:6] == {2{$past(fe)}};
   endproperty
   a_b76: assert property (p_b76) else $error("ident bits 7:6 wrong");
   property p_hs;
      $past(id_rd && !en[3]) |-> rdata_out[3:0] != 4'h0;
   endproperty
   a_hs: assert property (p_hs) else $error("handshake shown while off");
   property p_line;
      $past(id_rd && !en[2]) |-> rdata_out[3:0] != 4'h6;
   endproperty
   a_line: assert property (p_line) else $error("line status shown while off");
   property p_tx;
      $past(id_rd && !en[1]) |-> rdata_out[3:0] != 4'h2;
   endproperty
   a_tx: assert property (p_tx) else $error("tx empty shown while off");
   property p_rx;
      $past(id_rd && !en[0]) |-> rdata_out[2:0] != 3'h4;
   endproperty
   a_rx: assert property (p_rx) else $error("rx ready shown while off");
   c_irq: cover property ($rose(irq_out));
   c_line: cover property ($past(id_rd) && rdata_out[3:0] == 4'h6);
   c_evt: cover property ($rose(evt_irq_out));
endmodule // uart_irq_chk
bind uart_interrupt_identify_enable uart_irq_chk i_uart_irq_chk (
   .clk_sys_in(clk_sys_in),
   .rstn_in(rstn_in),
   .addr_in(addr_in),
   .wdata_in(wdata_in),
   .wr_in(wr_in),
   .rd_in(rd_in),
   .rdata_out(rdata_out),
   .irq_out(irq_out),
   .evt_irq_out(evt_irq_out)
);
`default_nettype wire

/* sim/uart_interrupt_identify_enable_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_identify_enable_tb;
   logic clk, rstn, wr, rd, tick, txe, irq, eirq;
   logic [2:0] addr;
   logic [7:0] wd, rdat, txd;
   logic [4:0] cnt;
   logic [3:0] le, hs;
   logic [4:0] lv [4];
   int err_count, checked, cyc;
   uart_interrupt_identify_enable i_uart_interrupt_identify_enable (
      .clk_sys_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wd),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .rx_byte_in(8'h00),
      .rx_count_in(cnt), .bit_tick_in(tick), .overrun_flag_in(le[0]),
      .parity_error_flag_in(le[1]), .framing_error_flag_in(le[2]),
      .break_detect_flag_in(le[3]), .tx_empty_in(txe),
      .clear_to_send_change_in(hs[0]), .data_set_ready_change_in(hs[1]),
      .ring_trailing_edge_in(hs[2]), .carrier_detect_change_in(hs[3]),
      .modem_lines_in(4'h0), .rx_read_out(), .tx_write_out(), .tx_data_out(txd),
      .irq_out(irq), .evt_irq_out(eirq));
   ////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////
   // Bus and compare tasks
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wt(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task rd1(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
   endtask
   task rc(input logic [2:0] a, input logic [7:0] e);
      rd1(a);
      chk(rdat, e);
   endtask
   task pulse(input logic [3:0] l, input logic [3:0] h);
      @(posedge clk);
      le <= l;
      hs <= h;
      @(posedge clk);
      le <= 4'h0;
      hs <= 4'h0;
   endtask
   task ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
   endtask
   task print_verdict;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rstn, wr, rd, tick, txe, addr, wd, cnt, le, hs} = '0;
      {err_count, checked, cyc} = '0;
      lv = '{5'h01, 5'h04, 5'h08, 5'h0E};
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rc(3'h1, 8'h00);
      rc(3'h2, 8'h01);
      wt(3'h1, 8'hFF);
      rc(3'h1, 8'h0F);
      wt(3'h1, 8'h00);
      pulse(4'h1, 4'h0);
      chk(irq, 1'b0);
      wt(3'h1, 8'h04);
      rc(3'h2, 8'h06);
      wt(3'h1, 8'h00);
      chk(irq, 1'b0);
      wt(3'h1, 8'h0C);
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i, 4'h1 << i);
         rc(3'h2, 8'h06);
         rd1(3'h5);
         rc(3'h2, 8'h00);
         rd1(3'h6);
         rc(3'h2, 8'h01);
      end
      // All sources but the timeout at once, drained in priority order
      wt(3'h1, 8'h0F);
      cnt <= 5'h01;
      txe <= 1'b1;
      pulse(4'h2, 4'h4);
      chk(irq, 1'b1);
      rc(3'h2, 8'h06);
      rd1(3'h5);
      rc(3'h2, 8'h04);
      cnt <= 5'h00;
      rc(3'h2, 8'h02);
      rc(3'h2, 8'h00);
      rd1(3'h6);
      rc(3'h2, 8'h01);
      chk(irq, 1'b0);
      // Gating of tx empty and rx ready
      wt(3'h1, 8'h0D);
      txe <= 1'b0;
      rc(3'h2, 8'h01);
      txe <= 1'b1;
      rc(3'h2, 8'h01);
      wt(3'h1, 8'h0E);
      rc(3'h2, 8'h02);
      txe <= 1'b0;
      rc(3'h2, 8'h01);
      txe <= 1'b1;
      wt(3'h0, 8'h55);
      chk(txd, 8'h55);
      rc(3'h2, 8'h01);
      cnt <= 5'h01;
      rc(3'h2, 8'h01);
      wt(3'h1, 8'h01);
      rc(3'h2, 8'h04);
      // Trigger levels in FIFO mode
      for (int j = 0; j < 4; j++) begin
         wt(3'h2, {j[1:0], 6'h01});
         cnt <= lv[j] - 5'h01;
         rc(3'h2, 8'hC1);
         cnt <= lv[j];
         rc(3'h2, 8'hC4);
      end
      // Receive timeout after four characters
      cnt <= 5'h02;
      ticks(39);
      rc(3'h2, 8'hC1);
      ticks(1);
      rc(3'h2, 8'hCC);
      rd1(3'h0);
      rc(3'h2, 8'hC1);
      cnt <= 5'h00;
      wt(3'h2, 8'h00);
      // Event status, mask and clear
      wt(3'h4, 8'h01);
      wt(3'h1, 8'h04);
      pulse(4'h8, 4'h0);
      #1 chk(eirq, 1'b1);
      rc(3'h3, 8'h03);
      wt(3'h3, 8'h01);
      chk(eirq, 1'b0);
      rc(3'h3, 8'h02);
      rd1(3'h5);
      wt(3'h3, 8'h02);
      rc(3'h3, 8'h00);
      rc(3'h7, 8'h00);
      print_verdict;
   end
endmodule // uart_interrupt_identify_enable_tb
`default_nettype wire
